// ---- src/dwc_drive.sv ----
// Drive-end write, erase, head select and door lock control.
// Assumes link lines are synchronous to pclk.
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module dwc_drive
    import dwc_pkg::*;
#(
    parameter dwc_lock_t     LOCK_SRC   = LOCK_LATCH,
    parameter dwc_side_src_t SIDE_SRC   = SIDE_FROM_SIDE,
    parameter bit            AUTO_ERASE = 1'b1,
    parameter bit            PROT_BLOCK = 1'b1,
    parameter int            LEAD_CYC   = ERASE_LEAD_CYC,
    parameter int            TAIL_CYC   = ERASE_TAIL_CYC
) (
    input  wire logic   pclk,               // Clock
    input  wire logic   presetn,            // Power-on clear, low
    dwc_link_if.drive   link,               // Host lines
    input  wire logic   ready,              // Disk ready
    input  wire logic   protect_notch_seen, // Protect_notch_seen
    input  wire logic   power_fail,         // Supply monitor fault
    output logic        write_current_on,   // Write current gate
    output logic        write_winding,      // Winding select
    output logic        low_current,        // Reduced current
    output logic        erase_current_on,   // Erase current gate
    output logic        head1_sel,          // Head 1 select
    output logic        head0_sel,          // Head 0 select
    output logic        door_lock,          // Lock solenoid
    output logic        activity_lamp       // Activity lamp
);
    logic             usage_latch_ff;
    logic             record_ff;
    logic             erase_drive_on_ff;
    logic [TMR_W-1:0] erase_lead_timer_ff;
    logic [TMR_W-1:0] erase_tail_timer_ff;
    logic             record_enable_int;
    logic             upper;
    logic             lock_src;
    logic             erase_want;
    logic             prot_ff;

    // Usage latch tracks in-use while selected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            usage_latch_ff <= 1'b0;
        end else if (link.select) begin
            usage_latch_ff <= link.in_use;
        end
    end

    // Write enable gated by select and protect
    assign record_enable_int = link.write_req & link.select & !power_fail
        & !(PROT_BLOCK & protect_notch_seen);

    // Write flip-flop toggles per data pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            record_ff <= 1'b0;
        end else if (record_enable_int && link.flux_pulse_in) begin
            record_ff <= !record_ff;
        end
    end

    // Auto erase lead and tail timers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            erase_drive_on_ff   <= 1'b0;
            erase_lead_timer_ff <= '0;
            erase_tail_timer_ff <= '0;
        end else if (!AUTO_ERASE || power_fail) begin
            // Supply fault restarts the lead, so erase never beats write
            erase_drive_on_ff   <= 1'b0;
            erase_lead_timer_ff <= '0;
            erase_tail_timer_ff <= '0;
        end else if (record_enable_int) begin
            erase_tail_timer_ff <= '0;
            if (!erase_drive_on_ff) begin
                if (erase_lead_timer_ff == TMR_W'(LEAD_CYC - 1)) begin
                    erase_drive_on_ff <= 1'b1;
                end else begin
                    erase_lead_timer_ff <= erase_lead_timer_ff + 1'b1;
                end
            end
        end else begin
            erase_lead_timer_ff <= '0;
            if (erase_drive_on_ff) begin
                if (erase_tail_timer_ff == TMR_W'(TAIL_CYC - 1)) begin
                    erase_drive_on_ff <= 1'b0;
                end else begin
                    erase_tail_timer_ff <= erase_tail_timer_ff + 1'b1;
                end
            end
        end
    end

    // Erase source and power-fail block
    assign erase_want = (AUTO_ERASE ? erase_drive_on_ff : link.erase_req)
        & !power_fail;

    // Head select source
    always_comb begin
        unique case (SIDE_SRC)
            SIDE_FROM_SIDE: upper = !link.side_in;
            SIDE_FROM_STEP: upper = link.step_in;
            default:        upper = link.dsel_side;
        endcase
    end

    // Door lock source
    always_comb begin
        unique case (LOCK_SRC)
            LOCK_HEAD:  lock_src = link.head_engage_req;
            LOCK_SEL:   lock_src = link.select;
            LOCK_RDY:   lock_src = ready;
            LOCK_USE:   lock_src = link.in_use;
            LOCK_HD_US: lock_src = link.head_engage_req | link.in_use;
            LOCK_SL_US: lock_src = link.select | link.in_use;
            LOCK_RD_US: lock_src = ready | link.in_use;
            default:    lock_src = usage_latch_ff;
        endcase
    end

    // Registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_current_on <= 1'b0;
            write_winding    <= 1'b0;
            low_current      <= 1'b0;
            erase_current_on <= 1'b0;
            head1_sel        <= 1'b0;
            head0_sel        <= 1'b1;
            door_lock        <= 1'b0;
            activity_lamp    <= 1'b0;
            prot_ff          <= 1'b0;
        end else begin
            write_current_on <= record_enable_int;
            write_winding    <= record_ff;
            low_current      <= link.reduced_current_sel;
            erase_current_on <= erase_want;
            head1_sel        <= link.select & upper;
            head0_sel        <= !(link.select & upper);
            door_lock        <= lock_src;
            activity_lamp    <= lock_src;
            prot_ff          <= protect_notch_seen & link.select;
        end
    end

    assign link.write_protect = prot_ff;

endmodule : dwc_drive
`default_nettype wire

// ---- src/dwc_pkg.sv ----
// Shared constants and types for the diskette write control link.
// Assumes one 40 MHz clock and an active-low asynchronous reset.
// Behaviour
// - Usage latch follows in-use while selected
// - Latched lock stays until reselect, in-use off
// - Lamp lit whenever door lock energised
// - Lock source: single, OR-ed, or latch
// - Head 1 only when selected with upper side
// - Head select source: side, step-in, or selects
// - Write enable needs write, select, no protect
// - Each write pulse toggles write flip-flop while write enabled
// - Host asserts reduced current beyond track 43
// - Erase only when enabled; power fail blocks
// - Erase on after write on, off after
// - Auto erase uses lead and tail timers
// - Reset clears erase flop; manual follows host
// - Host starts write with select, load, write
// - Protect status reported only while selected
// - Protect inhibit configurable: block or report
// - Host keeps write gate off when reading
// - Lock sources include load, select, ready
package dwc_pkg;

    // Door lock source choices
    typedef enum logic [2:0] {
        LOCK_HEAD  = 3'b000,
        LOCK_SEL   = 3'b001,
        LOCK_RDY   = 3'b010,
        LOCK_USE   = 3'b011,
        LOCK_HD_US = 3'b100,
        LOCK_SL_US = 3'b101,
        LOCK_RD_US = 3'b110,
        LOCK_LATCH = 3'b111
    } dwc_lock_t;

    // Head select source choices
    typedef enum logic [1:0] {
        SIDE_FROM_SIDE = 2'b00,
        SIDE_FROM_STEP = 2'b01,
        SIDE_FROM_DSEL = 2'b10
    } dwc_side_src_t;

    // Erase delays as times and derived cycle counts
    localparam int CLK_MHZ         = 40;
    localparam int ERASE_LEAD_US   = 200;
    localparam int ERASE_TAIL_US   = 500;
    localparam int ERASE_LEAD_CYC  = ERASE_LEAD_US * CLK_MHZ;
    localparam int ERASE_TAIL_CYC  = ERASE_TAIL_US * CLK_MHZ;
    localparam int TMR_W           = 16;

    // Register offsets of the host controller
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ    = 8'h08;
    localparam logic [7:0] OFS_MASK   = 8'h0c;
    localparam logic [7:0] OFS_PULSE  = 8'h10;

    // Control bit positions
    localparam int C_SEL   = 0;
    localparam int C_HEAD_ENGAGE_REQ  = 1;
    localparam int C_WRITE = 2;
    localparam int C_ERASE = 3;
    localparam int C_USE   = 4;
    localparam int C_LOWI  = 5;
    localparam int C_SIDE  = 6;
    localparam int C_STEP  = 7;
    localparam int C_DSEL  = 8;

    // Interrupt bit positions
    localparam int I_PROT  = 0;
    localparam int I_PULSE = 1;
    localparam int I_W     = 2;

    localparam logic [8:0] CTRL_RST = 9'h000;

endpackage : dwc_pkg

// ---- src/dwc_link_if.sv ----
// Interface lines between host controller and drive.
// Assumes both ends share pclk.
`timescale 1ns/1ps
`default_nettype none
interface dwc_link_if;
    logic select;              // Drive select
    logic head_engage_req;     // Head load request
    logic write_req;           // Write request
    logic erase_req;           // Manual erase
    logic in_use;              // In-use level
    logic reduced_current_sel; // Reduced write current
    logic side_in;             // Side input, high is head 0
    logic step_in;             // Step-in line
    logic dsel_side;           // Second select line
    logic flux_pulse_in;       // Write data, one-cycle pulse
    logic write_protect;       // Protect status to host

    modport drive (input select, head_engage_req, write_req, erase_req,
                   in_use, reduced_current_sel, side_in, step_in,
                   dsel_side, flux_pulse_in, output write_protect);
    modport host  (output select, head_engage_req, write_req, erase_req,
                   in_use, reduced_current_sel, side_in, step_in,
                   dsel_side, flux_pulse_in, input write_protect);
endinterface : dwc_link_if
`default_nettype wire

// ---- src/dwc_host.sv ----
// Host controller: APB registers drive the drive interface lines.
// Assumes APB master on pclk; drive end joined by the bench.
`timescale 1ns/1ps
`default_nettype none
module dwc_host
    import dwc_pkg::*;
(
    input  wire logic        pclk,    // Clock
    input  wire logic        presetn, // Reset, low
    input  wire logic        psel,    // APB select
    input  wire logic        penable, // APB enable
    input  wire logic        pwrite,  // APB write
    input  wire logic [7:0]  paddr,   // APB address
    input  wire logic [31:0] pwdata,  // APB write data
    output logic [31:0]      prdata,  // APB read data
    output logic             pready,  // APB ready
    output logic             pslverr, // APB error
    output logic             irq,     // Interrupt level
    dwc_link_if.host         link     // Drive lines
);
    logic [8:0]     ctrl_ff;
    logic [I_W-1:0] irq_ff;
    logic [I_W-1:0] mask_ff;
    logic           pulse_ff;
    logic           prot_d_ff;
    logic           acc;
    logic           wr;
    logic           known;

    assign acc   = psel & penable;
    assign wr    = acc & pwrite;
    assign known = paddr == OFS_CTRL || paddr == OFS_STATUS
        || paddr == OFS_IRQ || paddr == OFS_MASK || paddr == OFS_PULSE;

    // Control register, keeps write off unless set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= CTRL_RST;
        end else if (wr && paddr == OFS_CTRL) begin
            ctrl_ff <= pwdata[8:0];
        end
    end

    // Write-data pulse, one cycle per write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_ff <= 1'b0;
        end else begin
            pulse_ff <= wr && paddr == OFS_PULSE && pwdata[0];
        end
    end

    // Sticky events, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff    <= '0;
            prot_d_ff <= 1'b0;
        end else begin
            prot_d_ff <= link.write_protect;
            irq_ff <= (irq_ff & ~((wr && paddr == OFS_IRQ) ? pwdata[I_W-1:0]
                                                          : '0))
                | {pulse_ff, link.write_protect & !prot_d_ff};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff <= '0;
        end else if (wr && paddr == OFS_MASK) begin
            mask_ff <= pwdata[I_W-1:0];
        end
    end

    // APB answer, zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            irq     <= 1'b0;
        end else begin
            pready  <= psel & !penable;
            pslverr <= psel & !penable & !known;
            irq     <= |(irq_ff & ~mask_ff); // Mask bit set hides event
            unique case (paddr)
                OFS_CTRL:   prdata <= {23'h0, ctrl_ff};
                OFS_STATUS: prdata <= {31'h0, link.write_protect};
                OFS_IRQ:    prdata <= {30'h0, irq_ff};
                OFS_MASK:   prdata <= {30'h0, mask_ff};
                default:    prdata <= 32'h0;
            endcase
        end
    end

    // Line drive from control bits
    assign link.select              = ctrl_ff[C_SEL];
    assign link.head_engage_req     = ctrl_ff[C_HEAD_ENGAGE_REQ];
    assign link.write_req           = ctrl_ff[C_WRITE];
    assign link.erase_req           = ctrl_ff[C_ERASE];
    assign link.in_use              = ctrl_ff[C_USE];
    assign link.reduced_current_sel = ctrl_ff[C_LOWI];
    assign link.side_in             = ctrl_ff[C_SIDE];
    assign link.step_in             = ctrl_ff[C_STEP];
    assign link.dsel_side           = ctrl_ff[C_DSEL];
    assign link.flux_pulse_in       = pulse_ff;

endmodule : dwc_host
`default_nettype wire

// ---- dv/dwc_assertions.sv ----
// Checker for the drive link lines and the drive outputs.
// Assumes one clock pclk, reset presetn, erase lead of 8 cycles or more.
`timescale 1ns/1ps
`default_nettype none
module dwc_assertions (
    input wire logic pclk,               // Clock
    input wire logic presetn,            // Reset, low
    input wire logic select,             // Select
    input wire logic write_req,          // Write request
    input wire logic side_in,            // Side line
    input wire logic flux_pulse_in,      // Write pulse
    input wire logic write_protect,      // Protect status
    input wire logic protect_notch_seen, // Protect_notch_seen
    input wire logic power_fail,         // Supply fault
    input wire logic write_current_on,   // Write current
    input wire logic write_winding,      // Winding
    input wire logic erase_current_on,   // Erase current
    input wire logic head0_sel,          // Head 0
    input wire logic head1_sel,          // Head 1
    input wire logic door_lock,          // Lock
    input wire logic activity_lamp       // Lamp
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Outputs tied to their causes one cycle earlier; heads exclusive and lamp equal to lock in the same cycle
    prot_status_a: assert property (1'b1 |=>
        write_protect == $past(protect_notch_seen && select))
        else $error("protect status wrong");
    head_choice_a: assert property (1'b1 |=>
        head1_sel == $past(select && !side_in))
        else $error("head choice wrong");
    head_excl_a: assert property (head0_sel != head1_sel)
        else $error("heads not exclusive");
    lamp_lock_a: assert property (activity_lamp == door_lock)
        else $error("lamp differs from lock");
    write_gate_a: assert property (1'b1 |=> write_current_on ==
        $past(write_req && select && !protect_notch_seen && !power_fail))
        else $error("write gate wrong");
    // Winding moves two cycles after a pulse, and after every enabled one while write current is on
    winding_hold_a: assert property (!flux_pulse_in |-> ##2
        $stable(write_winding)) else $error("winding moved");
    winding_flip_a: assert property (flux_pulse_in && write_req
        && select && write_current_on && !protect_notch_seen && !power_fail
        |-> ##2 $changed(write_winding)) else $error("winding held");
    // Erase trails write at both ends
    erase_order_a: assert property ($rose(erase_current_on) |->
        write_current_on) else $error("erase before write");
    erase_lead_a: assert property ($rose(write_current_on) |->
        !erase_current_on [*8]) else $error("erase lead short");
    erase_tail_a: assert property ($fell(write_current_on)
        && erase_current_on && !power_fail |-> erase_current_on [*8])
        else $error("erase tail short");

    cover property ($rose(erase_current_on));
    cover property ($changed(write_winding));
    cover property (write_protect);
    cover property (door_lock && !select);
endmodule : dwc_assertions
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench: APB host controller joined to the drive end.
// Assumes one 40 MHz clock; erase delays shortened to 8 and 12 cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dwc_pkg::*;
    typedef struct {logic [31:0] d, m; logic e;} dwc_exp_t;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, ready = 1'b1, notch = 1'b0, pfail = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rs = 32'h00012b70;
    logic [31:0] prdata;
    logic        pready, pslverr, irq, wc, ww, lc, ec, h1, h0, dl, al, w0;
    int          n_fail = 0, comparisons = 0, k;
    dwc_exp_t    exp_q[$], en;

    dwc_link_if link_i ();
    dwc_host dwc_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .link(link_i.host));
    dwc_drive #(.LEAD_CYC(8), .TAIL_CYC(12)) dwc_drive_i (.pclk(pclk),
        .presetn(presetn), .link(link_i.drive), .ready(ready),
        .protect_notch_seen(notch), .power_fail(pfail),
        .write_current_on(wc), .write_winding(ww), .low_current(lc),
        .erase_current_on(ec), .head1_sel(h1), .head0_sel(h0),
        .door_lock(dl), .activity_lamp(al));
    dwc_assertions dwc_assertions_i (.pclk(pclk), .presetn(presetn),
        .select(link_i.select), .write_req(link_i.write_req),
        .side_in(link_i.side_in), .flux_pulse_in(link_i.flux_pulse_in),
        .write_protect(link_i.write_protect), .protect_notch_seen(notch),
        .power_fail(pfail), .write_current_on(wc), .write_winding(ww),
        .erase_current_on(ec), .head0_sel(h0), .head1_sel(h1),
        .door_lock(dl), .activity_lamp(al));

    // Clock at 40 MHz
    always #12.5 pclk = ~pclk;

    function automatic logic [31:0] nxt_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt_rand

    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %b, seen %b", nm, e, g);
        end
    endtask : chk

    // One APB transfer; holds the request until pready is seen
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int t;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        // Samples pready at each rising edge, releases at that same edge
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 16);
        if (pready !== 1'b1) begin
            n_fail++;
            finish_test();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
                      input logic er);
        exp_q.push_back('{e, m, er});
        apb(1'b0, a, 32'h0);
    endtask : rd

    // Lets link and drive registers follow, then samples mid-cycle
    task automatic settle;
        repeat (4) @(posedge pclk);
        @(negedge pclk);
    endtask : settle

    // Takes the oldest note as each read answer appears
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            en = exp_q.pop_front();
            comparisons++;
            if ((prdata & en.m) !== en.d || pslverr !== en.e) begin
                n_fail++;
                $display("unexpected read %h: expected %h, seen %h", paddr,
                         {en.e, en.d}, {pslverr, prdata & en.m});
            end
        end
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        chk("head0", 1'b1, h0);
        chk("lock", 1'b0, dl);
        rd(OFS_CTRL, 32'h0, 32'h1ff, 1'b0);
        rd(8'h20, 32'h0, 32'h0, 1'b1);
        // Random side and reduced-current choices while selected
        for (int i = 0; i < 4; i++) begin
            rs = nxt_rand(rs);
            apb(1'b1, OFS_CTRL, {25'h0, rs[6:5], 5'h01});
            settle();
            chk("head1", ~rs[6], h1);
            chk("lowcur", rs[5], lc);
        end
        $display("test head choice done");
        // Write, random pulse count, erase on and off
        apb(1'b1, OFS_CTRL, 32'h7);
        settle();
        chk("wcur", 1'b1, wc);
        w0 = ww;
        rs = nxt_rand(rs);
        for (int i = 0; i <= rs[2:0]; i++) apb(1'b1, OFS_PULSE, 32'h1);
        settle();
        chk("winding", w0 ^ ~rs[0], ww);
        chk("erase", 1'b1, ec);
        rd(OFS_IRQ, 32'h2, 32'h2, 1'b0);
        apb(1'b1, OFS_IRQ, 32'h2);
        apb(1'b1, OFS_CTRL, 32'h3);
        k = 0;
        while (ec === 1'b1 && k < 40) begin
            @(negedge pclk);
            k++;
        end
        chk("erase_tail", 1'b1, k >= 10 && k < 40);
        $display("test write done");
        // Supply fault cuts both currents
        apb(1'b1, OFS_CTRL, 32'h7);
        repeat (12) @(posedge pclk);
        pfail <= 1'b1;
        settle();
        chk("wcur_pf", 1'b0, wc);
        chk("erase_pf", 1'b0, ec);
        @(posedge pclk);
        pfail <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h0);
        $display("test power fail done");
        // Protected disk: status, no write current, interrupt
        notch <= 1'b1;
        apb(1'b1, OFS_CTRL, 32'h7);
        settle();
        chk("wprot", 1'b1, link_i.write_protect);
        chk("wcur_prot", 1'b0, wc);
        rd(OFS_STATUS, 32'h1, 32'h1, 1'b0);
        chk("irq", 1'b1, irq);
        apb(1'b1, OFS_MASK, 32'h1);
        settle();
        chk("irq_mask", 1'b0, irq);
        apb(1'b1, OFS_MASK, 32'h0);
        apb(1'b1, OFS_IRQ, 32'h3);
        settle();
        chk("irq_clr", 1'b0, irq);
        apb(1'b1, OFS_CTRL, 32'h0);
        settle();
        chk("wprot_off", 1'b0, link_i.write_protect);
        @(posedge pclk);
        notch <= 1'b0;
        $display("test protect done");
        // Latched door lock survives deselection
        apb(1'b1, OFS_CTRL, 32'h11);
        settle();
        chk("lock_on", 1'b1, dl);
        chk("lamp_on", 1'b1, al);
        apb(1'b1, OFS_CTRL, 32'h0);
        settle();
        chk("lock_held", 1'b1, dl);
        apb(1'b1, OFS_CTRL, 32'h1);
        settle();
        chk("lock_off", 1'b0, dl);
        $display("test door lock done");
        finish_test();
    end
endmodule : testbench
`default_nettype wire
